// File: common/ram_card_pkg.sv
// Shared constants and carrier types for the battery-backed RAM card.
package ram_card_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int WIN_HI = 15;
  localparam int WIN_LO = 13;
  localparam int COL_HI = 12;
  localparam int COL_LO = 10;
  localparam int WORD_W = 10;
  localparam int COLS = 8;
  localparam int COL_SEL_W = 3;
  localparam int WIN_W = 3;

  // ==========================================================================
  // Slot start addresses, one 8K window each
  localparam logic [ADDR_W-1:0] SLOT0_BASE = 16'h4000;
  localparam logic [ADDR_W-1:0] SLOT1_BASE = 16'h6000;
  localparam logic [ADDR_W-1:0] SLOT2_BASE = 16'h8000;
  localparam logic [1:0] SLOT0 = 2'h0;
  localparam logic [1:0] SLOT1 = 2'h1;
  localparam logic [1:0] SLOT2 = 2'h2;

  // ==========================================================================
  // Population of the array
  localparam int COLS_4K = 4;
  localparam int COLS_8K = 8;
  localparam logic [DATA_W-1:0] FITTED_BITS = 8'hFC;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // ==========================================================================
  // Timing
  localparam int CLOCK_NS = 10;
  localparam int STRETCH_NS = 1000;
  localparam int STRETCH_CYC = (STRETCH_NS + CLOCK_NS - 1) / CLOCK_NS;

  // ==========================================================================
  // Bus request carrier
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic read;
    logic valid_memory_cycle;
    logic clk_high;
  } bus_req_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_STRETCH = 2'h1,
    ST_HOLD = 2'h3
  } access_e;

endpackage : ram_card_pkg

// File: dv/bus_master.sv
// Processor bus master model that runs memory cycles against the cards.
`timescale 1ns/10ps
module bus_master (
  // Clock
  input wire logic clock,
  // Answers from the cards
  input wire logic hold_off,
  input wire logic [7:0] dbus,
  // Bus request
  output ram_card_pkg::bus_req_s bus
);
  initial bus = '0;
  // Enter just after a rising edge; released lines show their inverse, not a kind copy.
  task automatic access(input logic [15:0] a, input logic rd, input logic [7:0] wd,
                        output logic [7:0] got, output int n);
    n = 0;
    bus.addr = a;
    bus.wdata = wd;
    bus.read = rd;
    bus.valid_memory_cycle = 1'b1;
    bus.clk_high = 1'b1;
    // Look one step past each edge, where hold_off has settled for the next edge.
    #1;
    while (hold_off === 1'b1 && n < 40) begin
      n++;
      @(posedge clock);
      #1;
    end
    // The cycle ends at the first edge that sees hold_off low; data stands until then.
    got = dbus;
    @(posedge clock);
    #1;
    bus.addr = ~bus.addr;
    bus.wdata = ~bus.wdata;
    bus.read = ~bus.read;
    bus.valid_memory_cycle = 1'b0;
    bus.clk_high = 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask : access
endmodule : bus_master

// File: dv/ram_card_chk.sv
// Port checker for the RAM card, bound to every card instance.
`timescale 1ns/10ps
module ram_card_chk #(
  parameter bit CARD_8K = 1'b1,
  parameter int STRETCH = ram_card_pkg::STRETCH_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Card inputs
  input wire logic [1:0] slot,
  input wire ram_card_pkg::bus_req_s bus,
  input wire logic power_fail,
  // Card outputs
  input wire logic [ram_card_pkg::DATA_W-1:0] rdata,
  input wire logic rdata_oe,
  input wire logic hold_off,
  input wire logic reset_line_o,
  input wire logic reset_line_oe,
  input wire logic selected
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [2:0] base;
  logic qual;
  logic [7:0] run;
  logic [7:0] next_run;
  assign base = (slot == 2'h0) ? 3'h2 : (slot == 2'h1) ? 3'h3 : 3'h4;
  assign qual = bus.addr[15:13] == base && bus.clk_high && bus.valid_memory_cycle && !power_fail;
  // Length of the current hold-off stretch in clock cycles.
  always_comb begin
    next_run = hold_off ? run + 8'h01 : 8'h00;
  end
  always_ff @(posedge clock) begin
    run <= rst ? 8'h00 : next_run;
  end
  // ==========================================================================
  // Properties
  sequence s_start; qual && !selected; endsequence
  sequence s_end; selected ##1 !selected; endsequence
  property p_start; s_start |-> hold_off ##1 selected; endproperty
  property p_no_claim; !qual && !selected |-> !hold_off && !rdata_oe; endproperty
  property p_stretch; $fell(hold_off) |-> run == 8'(STRETCH + 1); endproperty
  property p_drive_read; selected && qual && bus.read |-> rdata_oe; endproperty
  property p_no_drive; !bus.read || !selected |-> !rdata_oe; endproperty
  property p_low_bits; rdata[1:0] == 2'h0; endproperty
  property p_reset_line; reset_line_oe == power_fail && reset_line_o == 1'b0; endproperty
  property p_pf_block; power_fail && !selected |=> !selected; endproperty
  property p_idle_data; s_end |=> rdata == 8'h00; endproperty
  property p_empty_col; !CARD_8K && selected && qual && bus.addr[12] |-> rdata == 8'h00; endproperty
  a_start: assert property (p_start)
    else $error("access did not start");
  a_no_claim: assert property (p_no_claim)
    else $error("card answered outside its cycle");
  a_stretch: assert property (p_stretch)
    else $error("stretch length wrong");
  a_drive_read: assert property (p_drive_read)
    else $error("read data not driven");
  a_no_drive: assert property (p_no_drive)
    else $error("data driven while unselected or writing");
  a_low_bits: assert property (p_low_bits)
    else $error("empty bit rows read nonzero");
  a_reset_line: assert property (p_reset_line)
    else $error("reset line drive wrong");
  a_pf_block: assert property (p_pf_block)
    else $error("access taken during power fail");
  a_idle_data: assert property (p_idle_data)
    else $error("data not cleared after access");
  a_empty_col: assert property (p_empty_col)
    else $error("empty column read nonzero");
endmodule : ram_card_chk

bind ram_card ram_card_chk #(.CARD_8K(CARD_8K), .STRETCH(STRETCH)) chk (.clock(clock),
  .rst(rst), .slot(slot), .bus(bus), .power_fail(power_fail), .rdata(rdata),
  .rdata_oe(rdata_oe), .hold_off(hold_off), .reset_line_o(reset_line_o),
  .reset_line_oe(reset_line_oe), .selected(selected));

// File: dv/tb_ram_card.sv
// Self-checking testbench for two RAM cards on one processor bus.
`timescale 1ns/10ps
module tb_ram_card;
  localparam int ST = 4;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic power_fail = 1'b0;
  logic [1:0] slot_a = 2'h0;
  ram_card_pkg::bus_req_s bus;
  logic [7:0] rd_a, rd_b, dbus;
  logic [7:0] idle_pat = 8'h00;
  logic oe_a, oe_b, hold_a, hold_b, rl_a, rl_b, rloe_a, rloe_b;
  int errors = 0;
  int n_checks = 0;
  always #5 clock = ~clock;
  always @(posedge clock) idle_pat <= idle_pat + 8'h01;
  // An undriven data bus wanders, so a stale byte never passes for an answer.
  assign dbus = oe_a ? rd_a : oe_b ? rd_b : idle_pat;
  // ==========================================================================
  // 8K card in the first slot, 4K card after it
  ram_card #(.CARD_8K(1'b1), .STRETCH(ST)) uut (.clock(clock), .rst(rst), .slot(slot_a),
    .bus(bus), .rdata(rd_a), .rdata_oe(oe_a), .hold_off(hold_a), .power_fail(power_fail),
    .reset_line_o(rl_a), .reset_line_oe(rloe_a), .selected());
  ram_card #(.CARD_8K(1'b0), .STRETCH(ST)) uut4 (.clock(clock), .rst(rst), .slot(2'h1),
    .bus(bus), .rdata(rd_b), .rdata_oe(oe_b), .hold_off(hold_b), .power_fail(power_fail),
    .reset_line_o(rl_b), .reset_line_oe(rloe_b), .selected());
  bus_master master (.clock(clock), .hold_off(hold_a | hold_b), .dbus(dbus), .bus(bus));
  // ==========================================================================
  // Helpers and scenarios
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic [15:0] a, input logic rd, input logic [7:0] wd,
                     input int en, input logic [7:0] ed);
    logic [7:0] got;
    int n;
    master.access(a, rd, wd, got, n);
    chk(8'(n), 8'(en));
    if (rd && en != 0) chk(got, ed);
  endtask : acc
  function automatic logic [15:0] ad(input logic [15:0] b, input int i);
    return b | 16'((i / 2) << 10) | ((i % 2 == 1) ? 16'h03FF : 16'h0000);
  endfunction : ad
  function automatic logic [7:0] pat(input int i);
    return {3'(i / 2), 1'(i % 2), 4'hF};
  endfunction : pat
  task automatic t_array(input logic [15:0] b, input bit big);
    for (int i = 0; i < 16; i++) acc(ad(b, i), 1'b0, pat(i), ST + 1, 8'h00);
    for (int i = 0; i < 16; i++) begin
      acc(ad(b, i), 1'b1, 8'h00, ST + 1, (big || i < 8) ? pat(i) & 8'hFC : 8'h00);
    end
  endtask : t_array
  task automatic t_window();
    logic [15:0] outside [3] = '{16'h2000, 16'hA000, 16'hE000};
    foreach (outside[k]) acc(outside[k], 1'b1, 8'h00, 0, 8'h00);
  endtask : t_window
  task automatic t_slot();
    slot_a = 2'h2;
    acc(16'h8000, 1'b1, 8'h00, ST + 1, 8'h0C);
    acc(16'h4000, 1'b1, 8'h00, 0, 8'h00);
    slot_a = 2'h3;
    acc(16'h8000, 1'b1, 8'h00, ST + 1, 8'h0C);
    slot_a = 2'h0;
  endtask : t_slot
  task automatic t_pf();
    acc(16'h4005, 1'b0, 8'hAC, ST + 1, 8'h00);
    power_fail = 1'b1;
    @(posedge clock);
    #1;
    chk(8'({rloe_a, rl_a, rloe_b, rl_b}), 8'h0A);
    acc(16'h4005, 1'b0, 8'h50, 0, 8'h00);
    acc(16'h4005, 1'b1, 8'h00, 0, 8'h00);
    power_fail = 1'b0;
    acc(16'h4005, 1'b1, 8'h00, ST + 1, 8'hAC);
  endtask : t_pf
  task automatic print_verdict();
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (12) @(posedge clock);
    #1;
    rst = 1'b0;
    t_array(16'h4000, 1'b1);
    t_array(16'h6000, 1'b0);
    t_window();
    t_slot();
    t_pf();
    print_verdict();
  end
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
endmodule : tb_ram_card

// File: hw/access_one_shot.sv
// Retriggerable-free one-shot that stretches a memory access.
`timescale 1ns/10ps
module access_one_shot #(
  parameter int CYCLES = ram_card_pkg::STRETCH_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Trigger and output
  input wire logic fire,
  output logic busy
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  // ==========================================================================
  // Counter
  // A trigger while running is ignored, so one access gives one pulse.
  always_comb begin
    next_count = count;
    if (count != '0) begin
      next_count = count - ONE;
    end else if (fire) begin
      next_count = LOAD;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign busy = (count != '0);

endmodule : access_one_shot

// File: hw/ram_bit_array.sv
// RAM array of 1K columns by bit rows with active-low device outputs.
`timescale 1ns/10ps
module ram_bit_array #(
  parameter int FITTED_COLS = ram_card_pkg::COLS_8K,
  parameter logic [7:0] FITTED = ram_card_pkg::FITTED_BITS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Column strobes and word address
  input wire logic [ram_card_pkg::COLS-1:0] col_strobe,
  input wire logic [ram_card_pkg::WORD_W-1:0] word,
  // Write port
  input wire logic write,
  input wire logic [ram_card_pkg::DATA_W-1:0] wdata,
  // Read port, low active as on the device pins
  output logic [ram_card_pkg::DATA_W-1:0] rdata_n
);

  localparam int DEPTH = ram_card_pkg::COLS * (1 << ram_card_pkg::WORD_W);

  logic [ram_card_pkg::DATA_W-1:0] next_rdata_n;
  logic [ram_card_pkg::DATA_W-1:0] cell_n;
  logic [ram_card_pkg::COL_SEL_W-1:0] col;
  logic hit;
  logic [ram_card_pkg::COL_SEL_W+ram_card_pkg::WORD_W-1:0] index;

  // ==========================================================================
  // Column encode; only fitted columns answer
  always_comb begin
    col = '0;
    hit = 1'b0;
    for (int c = 0; c < ram_card_pkg::COLS; c++) begin
      if (col_strobe[c] && (c < FITTED_COLS)) begin // see RULE_06
        col = ram_card_pkg::COL_SEL_W'(c);
        hit = 1'b1;
      end
    end
  end

  assign index = {col, word}; // see RULE_05

  // ==========================================================================
  // Bit rows
  // Contents are kept inverted; no reset, since the battery keeps them.
  for (genvar b = 0; b < ram_card_pkg::DATA_W; b++) begin : g_row
    if (FITTED[b]) begin : g_fit
      logic mem [0:DEPTH-1];
      always_ff @(posedge clock) begin
        if (write && hit) begin
          mem[index] <= ~wdata[b];
        end
      end
      assign cell_n[b] = hit ? mem[index] : 1'b1; // see RULE_08
    end else begin : g_empty
      assign cell_n[b] = 1'b1; // see RULE_07
    end
  end

  always_comb begin
    next_rdata_n = cell_n;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_n <= '1;
    end else begin
      rdata_n <= next_rdata_n;
    end
  end

endmodule : ram_bit_array

// File: hw/ram_card.sv
// Top of the battery-backed RAM card: decode, data gate, stretch, power fail.
//
// Function
// RULE_01 - The card compares bus address bits with its slot wiring and joins only its 8K window.
// RULE_02 - The column decoder is enabled only on a window match in clock phase with the qualifier.
// RULE_03 - In a selected cycle the data gate joins RAM and the byte bus, direction from read/write.
// RULE_04 - Each selected access fires a 1 us one-shot that holds the processor off.
// RULE_05 - The array is eight 1K columns picked by a 3-to-8 decode, low ten address bits common.
// RULE_06 - A 4K card fits only the low four columns, an 8K card all eight.
// RULE_07 - Only six data bits are stored; the two lowest bit rows are empty.
// RULE_08 - Device outputs are low active and pulled up, so empty bits and columns read zero.
// RULE_09 - Slot wiring puts the first card at 4000, the second at 6000 and the third at 8000.
// RULE_10 - Cards are fitted in slot order with 8K cards first, for 4K to 24K in total.
// RULE_11 - Power fail is driven onto the system reset line.
// RULE_12 - While power fail is active, RAM strobes and all writes are blocked.
// RULE_13 - Data drivers are off when the card is unselected or the cycle is a write.
// RULE_14 - A RAM write needs a selected, qualified cycle, read/write low and clock high.
`timescale 1ns/10ps
module ram_card #(
  parameter bit CARD_8K = 1'b1,
  parameter int STRETCH = ram_card_pkg::STRETCH_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,

  // Slot wiring from the motherboard
  input wire logic [1:0] slot,

  // Processor bus request
  input wire ram_card_pkg::bus_req_s bus,

  // Processor bus data return
  output logic [ram_card_pkg::DATA_W-1:0] rdata,
  output logic rdata_oe,

  // Cycle stretch to the processor
  output logic hold_off,

  // Power fail sense and reset line drive
  input wire logic power_fail,
  output logic reset_line_o,
  output logic reset_line_oe,

  // Access state for observation
  output logic selected
);

  // ==========================================================================
  // Declarations
  logic [ram_card_pkg::WIN_W-1:0] base_bits;
  logic [ram_card_pkg::ADDR_W-1:0] base;
  logic win_match;
  logic qualified;
  logic start;
  logic [ram_card_pkg::COL_SEL_W-1:0] col_addr;
  logic [ram_card_pkg::COLS-1:0] col_strobe;
  logic ram_write;
  logic [ram_card_pkg::DATA_W-1:0] ram_rdata_n;
  logic [ram_card_pkg::DATA_W-1:0] next_rdata;
  logic shot_busy;
  ram_card_pkg::access_e state;
  ram_card_pkg::access_e next_state;
  logic shot_seen;
  logic next_shot_seen;

  localparam int FITTED_COLS = CARD_8K ? ram_card_pkg::COLS_8K : ram_card_pkg::COLS_4K;

  // ==========================================================================
  // Window decode
  // Slot wiring gives the start address; the installer keeps slot order.
  always_comb begin
    case (slot) // see RULE_09
      ram_card_pkg::SLOT0: begin
        base = ram_card_pkg::SLOT0_BASE;
      end
      ram_card_pkg::SLOT1: begin
        base = ram_card_pkg::SLOT1_BASE;
      end
      ram_card_pkg::SLOT2: begin
        base = ram_card_pkg::SLOT2_BASE;
      end
      default: begin
        base = ram_card_pkg::SLOT2_BASE;
      end
    endcase
  end

  assign base_bits = base[ram_card_pkg::WIN_HI:ram_card_pkg::WIN_LO];

  // Only the top three address bits are compared, so each card owns 8K.
  assign win_match = (bus.addr[ram_card_pkg::WIN_HI:ram_card_pkg::WIN_LO]
                      == base_bits); // see RULE_01

  // Power fail acts like a missing qualifier, so nothing is strobed.
  assign qualified = win_match && bus.clk_high && bus.valid_memory_cycle
                     && !power_fail; // see RULE_02 see RULE_12

  // ==========================================================================
  // Column decode
  assign col_addr = bus.addr[ram_card_pkg::COL_HI:ram_card_pkg::COL_LO];

  for (genvar c = 0; c < ram_card_pkg::COLS; c++) begin : g_col
    assign col_strobe[c] = qualified
                           && (col_addr == ram_card_pkg::COL_SEL_W'(c)); // see RULE_05
  end

  // ==========================================================================
  // Access sequencer
  // One access per qualified cycle: the stretch fires on entry and the
  // machine waits in HOLD until the processor ends the cycle.
  assign start = (state == ram_card_pkg::ST_IDLE) && qualified;

  always_comb begin
    next_state = state;
    next_shot_seen = shot_seen;
    case (state)
      ram_card_pkg::ST_IDLE: begin
        next_shot_seen = 1'b0;
        if (qualified) begin
          next_state = ram_card_pkg::ST_STRETCH;
        end
      end
      ram_card_pkg::ST_STRETCH: begin
        if (shot_busy) begin
          next_shot_seen = 1'b1;
        end
        if (!qualified) begin
          next_state = ram_card_pkg::ST_IDLE;
        end else if (shot_seen && !shot_busy) begin
          next_state = ram_card_pkg::ST_HOLD;
        end
      end
      ram_card_pkg::ST_HOLD: begin
        if (!qualified) begin
          next_state = ram_card_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = ram_card_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ram_card_pkg::ST_IDLE;
      shot_seen <= 1'b0;
    end else begin
      state <= next_state;
      shot_seen <= next_shot_seen;
    end
  end

  assign selected = (state != ram_card_pkg::ST_IDLE);

  // ==========================================================================
  // Cycle stretch
  // The processor is held from the first qualified cycle until the
  // one-shot has run out, which covers the slow memory devices.
  access_one_shot #(
    .CYCLES(STRETCH)
  ) u_shot (
    .clock(clock),
    .rst(rst),
    .fire(start), // see RULE_04
    .busy(shot_busy)
  );

  assign hold_off = start || (state == ram_card_pkg::ST_STRETCH
                    && (shot_busy || !shot_seen)); // see RULE_04

  // ==========================================================================
  // Write strobe
  // A single write pulse on the first cycle keeps a long stretch from
  // rewriting the cell with data that may already be moving.
  assign ram_write = start && !bus.read; // see RULE_14 see RULE_12

  // ==========================================================================
  // RAM array
  ram_bit_array #(
    .FITTED_COLS(FITTED_COLS), // see RULE_06
    .FITTED(ram_card_pkg::FITTED_BITS) // see RULE_07
  ) u_array (
    .clock(clock),
    .rst(rst),
    .col_strobe(col_strobe),
    .word(bus.addr[ram_card_pkg::WORD_W-1:0]),
    .write(ram_write),
    .wdata(bus.wdata),
    .rdata_n(ram_rdata_n)
  );

  // ==========================================================================
  // Data gate
  // The low active device data is inverted back, so pulled-up empty
  // positions appear as zero on the bus.
  always_comb begin
    next_rdata = rdata;
    if (selected && bus.read) begin
      next_rdata = ~ram_rdata_n; // see RULE_08
    end else if (!selected) begin
      next_rdata = ram_card_pkg::DATA_ZERO;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= ram_card_pkg::DATA_ZERO;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Drivers follow the selected, qualified read; the registered data has
  // settled long before the stretch lets the processor sample it.
  assign rdata_oe = selected && qualified && bus.read; // see RULE_03 see RULE_13

  // ==========================================================================
  // Power fail drive
  // The reset line is open drain: the card only ever pulls it low.
  assign reset_line_o = 1'b0;
  assign reset_line_oe = power_fail; // see RULE_11

endmodule : ram_card
